// [logic/flash_pin_pkg.sv]
/*
 Shared constants and types for the flash disk host pin interface.
 Assumes a single 100 MHz clock domain on both ends.
*/
package flash_pin_pkg;
  localparam int ADDR_W          = 13;
  localparam int DATA_W          = 16;
  localparam int BYTE_W          = 8;
  localparam int ID_W            = 2;
  localparam int WIN_W           = 12;
  localparam int CLK_PERIOD_NS   = 10;
  localparam int INIT_TIME_NS    = 2000;
  localparam int INIT_CYCLES     = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W           = 16;
  // Device window register map (word index in address bits above bit 0)
  localparam logic [WIN_W-1:0] REG_DATA     = 12'h000;
  localparam logic [WIN_W-1:0] REG_STATUS   = 12'h001;
  localparam logic [WIN_W-1:0] REG_PROT     = 12'h002;
  localparam logic [WIN_W-1:0] REG_EVENT    = 12'h003;
  localparam logic [WIN_W-1:0] REG_IRQ_EN   = 12'h004;
  localparam logic [WIN_W-1:0] REG_IRQ_CLR  = 12'h005;
  localparam logic [WIN_W-1:0] REG_DMA      = 12'h006;
  localparam logic [WIN_W-1:0] REG_SLEEP    = 12'h007;
  // Host controller register map
  localparam logic [3:0] HREG_ADDR   = 4'h0;
  localparam logic [3:0] HREG_WDATA  = 4'h1;
  localparam logic [3:0] HREG_CMD    = 4'h2;
  localparam logic [3:0] HREG_RDATA  = 4'h3;
  localparam logic [3:0] HREG_STATUS = 4'h4;
  localparam logic [3:0] HREG_EVT    = 4'h5;
  localparam logic [3:0] HREG_EN     = 4'h6;
  localparam logic [3:0] HREG_CLR    = 4'h7;
  localparam logic [3:0] HREG_PINS   = 4'h8;
  // Command bits
  localparam int CMD_WRITE = 0;
  localparam int CMD_READ  = 1;
  localparam int CMD_SLEEP = 2;
  // Host event bits
  localparam int EVT_DONE  = 0;
  localparam int EVT_IRQ   = 1;
  localparam int EVT_DMA   = 2;
  localparam int EVT_READY = 3;
  localparam int EVT_W     = 4;
  localparam int STROBE_CYCLES = 3;
  localparam logic [DATA_W-1:0] FILL_RESET = 16'h0000;

  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_SETUP = 2'b01,
    H_PULSE = 2'b11,
    H_HOLD  = 2'b10
  } host_state_type;

  typedef enum logic [1:0] {
    D_INIT  = 2'b00,
    D_READY = 2'b01,
    D_SLEEP = 2'b11
  } dev_state_type;
endpackage

// [logic/flash_pin_if.sv]
/*
 Pin bundle between the flash disk device and the host bus controller.
 Two-way pins are split into in, out and enable (low drives); open-drain pins into in and enable.
*/
`timescale 1ns/1ps
interface flash_pin_if;
  import flash_pin_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] data_host_out;
  logic [DATA_W-1:0] data_host_oe_n;
  logic [DATA_W-1:0] data_dev_out;
  logic [DATA_W-1:0] data_dev_oe_n;
  logic [DATA_W-1:0] data_in;
  logic              chip_en_n;
  logic              write_en_n;
  logic              out_en_n;
  logic              lock_n;
  logic              busy_oe_n;
  logic              busy_in;
  logic              transfer_request_oe_n;
  logic              transfer_request_in;
  logic              irq_oe_n;
  logic              irq_in;
  logic              narrow_mode_pullup;

  modport device (
    input  addr, data_in, chip_en_n, write_en_n, out_en_n, lock_n,
    output data_dev_out, data_dev_oe_n, busy_oe_n, transfer_request_oe_n,
    output irq_oe_n, narrow_mode_pullup
  );
  modport host (
    input  data_in, busy_in, transfer_request_in, irq_in,
    output addr, data_host_out, data_host_oe_n, chip_en_n, write_en_n,
    output out_en_n, lock_n
  );
endinterface

// [logic/strap_sync.sv]
/*
 Two-stage synchroniser for a bus of pin levels.
 Assumes the inputs are asynchronous to ref_clk.
*/
`timescale 1ns/1ps
module strap_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // Levels
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync
);
  logic [WIDTH-1:0] meta_reg;

  initial begin
    if (WIDTH < 1) $error("WIDTH must be positive");
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      pin_sync <= '0;
    end else begin
      meta_reg <= pin_in;
      pin_sync <= meta_reg;
    end
  end
endmodule

// [logic/flash_disk_device.sv]
/*
 Device end of the flash disk host pin interface: strap capture, busy
 during initialization, small register window, lock protection, sleep in wide mode only,
 DMA and interrupt requests.
 Assumes the host end drives the pins through flash_pin_if.host.
*/
`timescale 1ns/1ps
module flash_disk_device #(
  parameter int INIT_COUNT = flash_pin_pkg::INIT_CYCLES
) (
  // Clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  // Pins
  flash_pin_if.device                     pins,
  // Straps
  input  wire logic                       width_strap,
  input  wire logic [flash_pin_pkg::ID_W-1:0] cascade_position,
  // Device-side data source for the transfer register
  input  wire logic [flash_pin_pkg::DATA_W-1:0] fill_data,
  input  wire logic                       dma_ready,
  // Status
  output logic                            wide_mode,
  output logic [flash_pin_pkg::ID_W-1:0]  position,
  output logic                            sleeping,
  output logic                            protect_active,
  output logic [flash_pin_pkg::DATA_W-1:0] store_data,
  output logic                            store_valid
);
  import flash_pin_pkg::*;

  initial begin
    if (INIT_COUNT < 1 || INIT_COUNT >= (1 << CNT_W)) $error("INIT_COUNT out of range");
  end

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] data_s;
  logic              ce_s_n;
  logic              we_s_n;
  logic              oe_s_n;
  logic              lock_s_n;
  logic              width_s;
  logic [ID_W-1:0]   id_s;

  strap_sync #(.WIDTH(ADDR_W + DATA_W + 4 + 1 + ID_W)) u_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .pin_in   ({pins.addr, pins.data_in, pins.chip_en_n, pins.write_en_n,
                pins.out_en_n, pins.lock_n, width_strap, cascade_position}),
    .pin_sync ({addr_s, data_s, ce_s_n, we_s_n, oe_s_n, lock_s_n, width_s, id_s})
  );

  // ----------------------------------------------------------------
  // Strap capture and initialization
  // ----------------------------------------------------------------
  dev_state_type     state_reg;
  logic [CNT_W-1:0]  init_cnt_reg;
  logic              busy_oe_n_reg;
  logic              sleep_next;

  // Straps taken once when initialization ends
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg     <= D_INIT;
      init_cnt_reg  <= '0;
      wide_mode     <= 1'b0;
      position      <= '0;
      busy_oe_n_reg <= 1'b0;
    end else if (state_reg == D_INIT) begin
      init_cnt_reg <= init_cnt_reg + 1'b1;
      if (init_cnt_reg == CNT_W'(INIT_COUNT - 1)) begin
        state_reg     <= D_READY;
        wide_mode     <= width_s;
        position      <= id_s;
        busy_oe_n_reg <= 1'b1;
      end
    end else begin
      state_reg <= sleep_next ? D_SLEEP : D_READY;
    end
  end

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  logic              ready;
  logic              sleep_pin;
  logic [WIN_W-1:0]  word_idx;
  logic [ADDR_W-1:0] full_addr;
  logic              access;
  logic              we_d_reg;
  logic              we_rise;
  logic              my_chip;

  assign ready     = (state_reg != D_INIT);
  // Wide mode: pin 0 is the sleep control, address bit 0 reads as zero
  assign sleep_pin  = wide_mode & addr_s[0];
  assign sleep_next = sleep_pin;
  assign full_addr  = wide_mode ? {addr_s[ADDR_W-1:1], 1'b0} : addr_s;
  assign word_idx   = full_addr[ADDR_W-1:1];
  // Position selects a quarter of the window by the top two address bits; words below 8 answer at any position
  assign my_chip    = (full_addr[ADDR_W-1 -: ID_W] == position) | (word_idx < 12'h008);
  assign access     = ready && (state_reg != D_SLEEP) && !ce_s_n && my_chip;
  assign we_rise    = we_s_n & ~we_d_reg;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] prot_reg;
  logic [EVT_W-1:0]  event_reg;
  logic [EVT_W-1:0]  irq_en_reg;
  logic              dma_en_reg;
  logic [DATA_W-1:0] wdata;
  logic              wr;
  logic [EVT_W-1:0]  ev_set;
  logic              blocked;

  // Narrow mode: upper data byte ignored, taken as zero on writes
  assign wdata   = wide_mode ? data_s : {{BYTE_W{1'b0}}, data_s[BYTE_W-1:0]};
  assign wr      = access && we_rise;
  assign blocked = !lock_s_n && prot_reg[0];
  // Data event only for writes that were taken
  assign ev_set  = {1'b0, dma_ready & dma_en_reg, wr & blocked,
                    wr & !blocked & (word_idx == REG_DATA)};

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      we_d_reg    <= 1'b1;
      prot_reg    <= '0;
      irq_en_reg  <= '0;
      dma_en_reg  <= 1'b0;
      store_data  <= FILL_RESET;
      store_valid <= 1'b0;
    end else begin
      we_d_reg    <= we_s_n;
      store_valid <= 1'b0;
      if (wr) begin
        case (word_idx)
          REG_DATA: begin
            if (!blocked) begin
              store_data  <= wdata;
              store_valid <= 1'b1;
            end
          end
          REG_PROT: begin
            if (lock_s_n) prot_reg <= wdata;
          end
          REG_IRQ_EN: irq_en_reg <= wdata[EVT_W-1:0];
          REG_DMA:    dma_en_reg <= wdata[0];
          default: ;
        endcase
      end
    end
  end

  // Set wins over clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      event_reg <= '0;
    end else begin
      event_reg <= (event_reg & ~((wr && word_idx == REG_IRQ_CLR) ? wdata[EVT_W-1:0] : '0))
                   | ev_set;
    end
  end

  // ----------------------------------------------------------------
  // Read path and open-drain outputs
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] data_out_reg;
  logic [DATA_W-1:0] data_oe_n_reg;
  logic              drive;
  logic              irq_oe_n_reg;
  logic              dma_oe_n_reg;
  logic              pullup_reg;

  assign drive = access && !oe_s_n && we_s_n;
  assign rdata = (word_idx == REG_DATA)   ? fill_data :
                 (word_idx == REG_STATUS) ? {{(DATA_W-6){1'b0}}, blocked, sleeping,
                                             position, wide_mode, ready} :
                 (word_idx == REG_PROT)   ? prot_reg :
                 (word_idx == REG_EVENT)  ? {{(DATA_W-EVT_W){1'b0}}, event_reg} :
                 (word_idx == REG_IRQ_EN) ? {{(DATA_W-EVT_W){1'b0}}, irq_en_reg} :
                 '0;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      data_out_reg   <= '0;
      data_oe_n_reg  <= '1;
      irq_oe_n_reg   <= 1'b1;
      dma_oe_n_reg   <= 1'b1;
      pullup_reg     <= 1'b0;
      sleeping       <= 1'b0;
      protect_active <= 1'b0;
    end else begin
      data_out_reg   <= rdata;
      data_oe_n_reg  <= drive ? (wide_mode ? '0 : {{BYTE_W{1'b1}}, {BYTE_W{1'b0}}}) : '1;
      irq_oe_n_reg   <= ~|(event_reg & irq_en_reg);
      dma_oe_n_reg   <= ~(dma_en_reg & dma_ready & ready);
      pullup_reg     <= ready ? ~wide_mode : ~width_s;
      sleeping       <= (state_reg == D_SLEEP);
      protect_active <= blocked;
    end
  end

  assign pins.data_dev_out          = data_out_reg;
  assign pins.data_dev_oe_n         = data_oe_n_reg;
  assign pins.busy_oe_n             = busy_oe_n_reg;
  assign pins.irq_oe_n              = irq_oe_n_reg;
  assign pins.transfer_request_oe_n = dma_oe_n_reg;
  assign pins.narrow_mode_pullup    = pullup_reg;
endmodule

// [logic/flash_host_ctrl.sv]
/*
 Host end: memory bus controller that drives the device pins from
 software commands held in its own registers.
 Assumes the device end sits on flash_pin_if.device.
*/
`timescale 1ns/1ps
module flash_host_ctrl (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst,
  // Pins
  flash_pin_if.host                pins,
  // Software port
  input  wire logic [3:0]          sw_addr,
  input  wire logic [15:0]         sw_wdata,
  input  wire logic                sw_write,
  input  wire logic                sw_read,
  output logic      [15:0]         sw_rdata,
  // Interrupt
  output logic                     host_irq
);
  import flash_pin_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] din_s;
  logic              busy_s;
  logic              dreq_s;
  logic              irq_s;

  // Request lines inverted so cleared flops mean idle after reset
  strap_sync #(.WIDTH(DATA_W + 3)) u_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .pin_in   ({pins.data_in, pins.busy_in, ~pins.transfer_request_in, ~pins.irq_in}),
    .pin_sync ({din_s, busy_s, dreq_s, irq_s})
  );

  // ----------------------------------------------------------------
  // Registers and bus cycle engine
  // ----------------------------------------------------------------
  host_state_type    state_reg;
  logic [1:0]        cnt_reg;
  logic              is_read_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic              sleep_reg;
  logic              lock_reg;
  logic [EVT_W-1:0]  evt_reg;
  logic [EVT_W-1:0]  en_reg;
  logic              done_pulse;
  logic              busy_d_reg;
  logic              start;
  logic              cmd_go;
  logic [EVT_W-1:0]  ev_set;
  logic [EVT_W-1:0]  ev_clr;

  assign cmd_go = sw_write && sw_addr == HREG_CMD && state_reg == H_IDLE;
  // Host keeps off the bus while the device is initializing
  assign start  = cmd_go && busy_s && (sw_wdata[CMD_WRITE] | sw_wdata[CMD_READ]);
  assign ev_set = {busy_s & ~busy_d_reg, dreq_s, irq_s, done_pulse};
  assign ev_clr = (sw_write && sw_addr == HREG_CLR) ? sw_wdata[EVT_W-1:0] : '0;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg   <= H_IDLE;
      cnt_reg     <= '0;
      is_read_reg <= 1'b0;
      addr_reg    <= '0;
      wdata_reg   <= '0;
      rdata_reg   <= '0;
      sleep_reg   <= 1'b0;
      lock_reg    <= 1'b0;
      en_reg      <= '0;
      done_pulse  <= 1'b0;
      busy_d_reg  <= 1'b0;
    end else begin
      done_pulse <= 1'b0;
      busy_d_reg <= busy_s;
      if (sw_write && sw_addr == HREG_ADDR)  addr_reg  <= sw_wdata[ADDR_W-1:0];
      if (sw_write && sw_addr == HREG_WDATA) wdata_reg <= sw_wdata;
      if (sw_write && sw_addr == HREG_EN)    en_reg    <= sw_wdata[EVT_W-1:0];
      if (sw_write && sw_addr == HREG_PINS)  lock_reg  <= sw_wdata[0];
      if (cmd_go) sleep_reg <= sw_wdata[CMD_SLEEP];
      case (state_reg)
        H_IDLE: begin
          if (start) begin
            is_read_reg <= sw_wdata[CMD_READ];
            state_reg   <= H_SETUP;
          end
        end
        H_SETUP: begin
          cnt_reg   <= '0;
          state_reg <= H_PULSE;
        end
        H_PULSE: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == 2'(STROBE_CYCLES)) begin
            state_reg <= H_HOLD;
          end
        end
        // Two cycles: read data passes the device register and both sync flops
        H_HOLD: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg[0]) begin
            if (is_read_reg) rdata_reg <= din_s;
            done_pulse <= 1'b1;
            state_reg  <= H_IDLE;
          end
        end
        default: state_reg <= H_IDLE;
      endcase
    end
  end

  // Set wins over clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      evt_reg <= '0;
    end else begin
      evt_reg <= (evt_reg & ~ev_clr) | ev_set;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive and software read
  // ----------------------------------------------------------------
  logic        active;
  logic [15:0] rd_mux;

  assign active = (state_reg != H_IDLE);
  assign rd_mux = (sw_addr == HREG_ADDR)   ? {3'h0, addr_reg} :
                  (sw_addr == HREG_WDATA)  ? wdata_reg :
                  (sw_addr == HREG_RDATA)  ? rdata_reg :
                  (sw_addr == HREG_STATUS) ? {12'h000, sleep_reg, active, busy_s, 1'b0} :
                  (sw_addr == HREG_EVT)    ? {12'h000, evt_reg} :
                  (sw_addr == HREG_EN)     ? {12'h000, en_reg} :
                  (sw_addr == HREG_PINS)   ? {13'h0000, irq_s, dreq_s, ~busy_s} :
                  16'h0000;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sw_rdata <= '0;
      host_irq <= 1'b0;
    end else begin
      sw_rdata <= sw_read ? rd_mux : 16'h0000;
      host_irq <= |(evt_reg & en_reg);
    end
  end

  // Address pin 0 carries sleep when idle in wide mode
  assign pins.addr           = active ? addr_reg : {{(ADDR_W-1){1'b0}}, sleep_reg};
  assign pins.chip_en_n      = ~active;
  assign pins.write_en_n     = ~(state_reg == H_PULSE && !is_read_reg);
  assign pins.out_en_n       = ~(state_reg == H_PULSE && is_read_reg);
  assign pins.data_host_out  = wdata_reg;
  assign pins.data_host_oe_n = (active && !is_read_reg) ? '0 : '1;
  assign pins.lock_n         = ~lock_reg;
endmodule

// [tb/flash_pin_props.sv]
/*
 Concurrent checks on the pins joining flash_disk_device and flash_host_ctrl.
 Assumes one clock domain and straps that stay static while out of reset.
*/
`timescale 1ns/1ps
module flash_pin_props #(
  parameter int INIT_COUNT = flash_pin_pkg::INIT_CYCLES
) (
  // Clock and reset
  input wire logic                              ref_clk,
  input wire logic                              rst,
  // Pins
  input wire logic [flash_pin_pkg::ADDR_W-1:0]  addr,
  input wire logic                              chip_en_n,
  input wire logic                              write_en_n,
  input wire logic                              out_en_n,
  input wire logic [flash_pin_pkg::DATA_W-1:0]  data_dev_oe_n,
  input wire logic [flash_pin_pkg::DATA_W-1:0]  data_host_oe_n,
  input wire logic                              busy_oe_n,
  input wire logic                              narrow_mode_pullup,
  // Device status
  input wire logic                              wide_mode
);
  import flash_pin_pkg::*;

  logic [CNT_W-1:0] busy_cnt;

  // --------------------------------------------------------------
  // Busy period length
  // --------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busy_cnt <= '0;
    end else if (!busy_oe_n) begin
      busy_cnt <= busy_cnt + 1'b1;
    end else begin
      busy_cnt <= '0;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence wr_pulse_s;
    !write_en_n [*4] ##1 write_en_n;
  endsequence

  sequence settled_s;
    busy_oe_n && $past(busy_oe_n) && $past(busy_oe_n, 2);
  endsequence

  busy_start_a: assert property ($past(rst) |-> !busy_oe_n)
    else $error("busy not driven after reset");
  busy_len_a: assert property (!busy_oe_n |-> busy_cnt <= INIT_COUNT + 2)
    else $error("busy held too long");
  busy_no_access_a: assert property (!busy_oe_n |-> chip_en_n)
    else $error("access while busy");
  bus_no_fight_a: assert property (((~data_dev_oe_n) & (~data_host_oe_n)) == '0)
    else $error("both ends drive data");
  dev_quiet_a: assert property (out_en_n [*6] |-> &data_dev_oe_n)
    else $error("device drives without output enable");
  narrow_upper_a: assert property (!wide_mode |-> &data_dev_oe_n[15:8])
    else $error("upper byte driven in narrow mode");
  pullup_mode_a: assert property (settled_s |-> narrow_mode_pullup == !wide_mode)
    else $error("pull-up does not follow width");
  strap_static_a: assert property (settled_s |-> $stable(wide_mode))
    else $error("width changed after capture");
  write_pulse_a: assert property ($fell(write_en_n) |-> wr_pulse_s)
    else $error("write strobe length wrong");
  write_chip_a: assert property (!write_en_n |-> !chip_en_n)
    else $error("write strobe outside chip enable");
  addr_hold_a: assert property (!chip_en_n && !$past(chip_en_n) |-> $stable(addr))
    else $error("address moved during access");
endmodule

// [tb/tb_top.sv]
/*
 Self-checking bench: host controller and device joined by the pin interface.
 Assumes the design package and interface are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
  import flash_pin_pkg::*;
  localparam int INIT_SIM = 10;
  logic              ref_clk = 1'b0;
  logic              rst = 1'b1;
  logic              width_strap = 1'b1;
  logic [ID_W-1:0]   cascade_position = '0;
  logic [DATA_W-1:0] fill_data = 16'h0000;
  logic [3:0]        sw_addr = 4'h0;
  logic [15:0]       sw_wdata = 16'h0000;
  logic              sw_write = 1'b0;
  logic              sw_read = 1'b0;
  logic [15:0]       sw_rdata;
  logic              host_irq;
  logic              wide_mode;
  logic              sleeping;
  logic              store_valid;
  logic [ID_W-1:0]   position;
  logic [DATA_W-1:0] store_data;
  logic [DATA_W-1:0] last_store = 16'h0000;
  logic              float_bit = 1'b0;
  logic              dma_ready = 1'b0;
  logic              protect_active;
  int                error_cnt = 0;
  int                cmp_count = 0;

  // --------------------------------------------------------------
  // Wire resolution and instances
  // --------------------------------------------------------------
  flash_pin_if pins_if ();
  wire [DATA_W-1:0] float_lvl = {{BYTE_W{pins_if.narrow_mode_pullup | float_bit}},
                                 {BYTE_W{float_bit}}};
  assign pins_if.data_in = (~pins_if.data_host_oe_n & pins_if.data_host_out)
                         | (~pins_if.data_dev_oe_n & pins_if.data_dev_out)
                         | (pins_if.data_host_oe_n & pins_if.data_dev_oe_n & float_lvl);
  assign pins_if.busy_in = pins_if.busy_oe_n;
  assign pins_if.transfer_request_in = pins_if.transfer_request_oe_n;
  assign pins_if.irq_in = pins_if.irq_oe_n;

  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) float_bit <= ~float_bit;
  always @(posedge ref_clk) if (store_valid === 1'b1) last_store <= store_data;

  flash_disk_device #(.INIT_COUNT(INIT_SIM)) flash_disk_device_i (
    .ref_clk(ref_clk), .rst(rst), .pins(pins_if.device), .width_strap(width_strap),
    .cascade_position(cascade_position), .fill_data(fill_data), .dma_ready(dma_ready),
    .wide_mode(wide_mode), .position(position), .sleeping(sleeping),
    .protect_active(protect_active), .store_data(store_data), .store_valid(store_valid));
  flash_host_ctrl flash_host_ctrl_i (
    .ref_clk(ref_clk), .rst(rst), .pins(pins_if.host), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_write(sw_write), .sw_read(sw_read), .sw_rdata(sw_rdata),
    .host_irq(host_irq));
  flash_pin_props #(.INIT_COUNT(INIT_SIM)) flash_pin_props_i (
    .ref_clk(ref_clk), .rst(rst), .addr(pins_if.addr), .chip_en_n(pins_if.chip_en_n),
    .write_en_n(pins_if.write_en_n), .out_en_n(pins_if.out_en_n),
    .data_dev_oe_n(pins_if.data_dev_oe_n), .data_host_oe_n(pins_if.data_host_oe_n),
    .busy_oe_n(pins_if.busy_oe_n), .narrow_mode_pullup(pins_if.narrow_mode_pullup),
    .wide_mode(wide_mode));

  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check16(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic sw_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_write <= 1'b1;
    @(posedge ref_clk);
    sw_write <= 1'b0;
  endtask

  task automatic sw_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_read <= 1'b1;
    @(posedge ref_clk);
    sw_read <= 1'b0;
    #1 d = sw_rdata;
  endtask

  task automatic wait_evt(input int b);
    logic [15:0] v;
    for (int i = 0; i < 100; i++) begin
      sw_rd(HREG_EVT, v);
      if (v[b] === 1'b1) begin
        sw_wr(HREG_CLR, 16'h0001 << b);
        return;
      end
    end
    error_cnt++;
    $display("Error at %0t: host event wait timed out", $time);
    tally_and_finish();
  endtask

  // Word index sits above address bit zero
  task automatic dev_acc(input int cmd, input logic [11:0] w, input logic [15:0] d);
    sw_wr(HREG_ADDR, {3'b000, w, 1'b0});
    sw_wr(HREG_WDATA, d);
    sw_wr(HREG_CMD, 16'h0001 << cmd);
    wait_evt(EVT_DONE);
  endtask

  task automatic wait_sleep(input logic exp);
    for (int i = 0; i < 30 && sleeping !== exp; i++) @(posedge ref_clk);
    #1 check16({15'h0, sleeping}, {15'h0, exp}, "sleep state");
  endtask

  // --------------------------------------------------------------
  // One pass per strap setting
  // --------------------------------------------------------------
  task automatic run_pass(input logic w, input logic [1:0] p, input logic [15:0] f);
    logic [15:0] v;
    logic [15:0] m;
    m = w ? 16'hffff : 16'h00ff;
    @(posedge ref_clk);
    rst <= 1'b1;
    width_strap <= w;
    cascade_position <= p;
    fill_data <= f;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    wait_evt(EVT_READY);
    check16({15'h0, wide_mode}, {15'h0, w}, "width");
    check16({14'h0, position}, {14'h0, p}, "position");
    check16({15'h0, pins_if.narrow_mode_pullup}, {15'h0, ~w}, "pull-up");
    dev_acc(CMD_WRITE, REG_DATA, ~f);
    check16(last_store & m, ~f & m, "stored data");
    dev_acc(CMD_READ, REG_DATA, 16'h0000);
    sw_rd(HREG_RDATA, v);
    check16(v & m, f & m, "read data");
    dev_acc(CMD_READ, REG_STATUS, 16'h0000);
    sw_rd(HREG_RDATA, v);
    check16(v & m, {12'h000, p, w, 1'b1} & m, "status");
    dev_acc(CMD_WRITE, REG_IRQ_EN, 16'h0001);
    dev_acc(CMD_WRITE, REG_DATA, f);
    wait_evt(EVT_IRQ);
    sw_wr(HREG_EN, 16'h0001 << EVT_IRQ);
    repeat (2) @(posedge ref_clk);
    #1 check16({15'h0, host_irq}, 16'h0001, "irq raised");
    dev_acc(CMD_WRITE, REG_IRQ_CLR, 16'h0001);
    check16({15'h0, pins_if.irq_in}, 16'h0001, "irq pin released");
    sw_wr(HREG_CLR, 16'h0001 << EVT_IRQ);
    repeat (2) @(posedge ref_clk);
    #1 check16({15'h0, host_irq}, 16'h0000, "irq cleared");
    dev_acc(CMD_WRITE, REG_DMA, 16'h0001);
    dma_ready <= 1'b1;
    wait_evt(EVT_DMA);
    check16({15'h0, pins_if.transfer_request_in}, 16'h0000, "dma pin low");
    dma_ready <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 check16({15'h0, pins_if.transfer_request_in}, 16'h0001, "dma pin released");
    dev_acc(CMD_WRITE, REG_PROT, 16'h0001);
    sw_wr(HREG_PINS, 16'h0001);
    dev_acc(CMD_WRITE, REG_DATA, 16'h0000);
    check16(last_store & m, f & m, "blocked write");
    check16({15'h0, protect_active}, 16'h0001, "protect active");
    sw_wr(HREG_PINS, 16'h0000);
    sw_wr(HREG_CMD, 16'h0001 << CMD_SLEEP);
    wait_sleep(w);
    sw_wr(HREG_CMD, 16'h0000);
    wait_sleep(1'b0);
  endtask

  initial begin
    run_pass(1'b1, 2'b00, 16'h5a3c);
    run_pass(1'b0, 2'b01, 16'hc3e1);
    run_pass(1'b1, 2'b10, 16'h0ff0);
    run_pass(1'b0, 2'b11, 16'h9687);
    tally_and_finish();
  end
endmodule
